/* File: dbt_pkg.sv */
/*
  Constants for the dual byte timer with toggle and PWM outputs:
  register indexes, control and prescaler field positions, reset values.
  Assumes a 32-bit APB with byte address equal to four times the index.
*/
package dbt_pkg;
  // ----------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [17:0] IDX_TIMER_CONTROL     = 18'h0FE18;
  localparam logic [17:0] IDX_PRESCALER_CONTROL = 18'h0FE19;
  localparam logic [17:0] IDX_LOW_COUNT         = 18'h0FE1A;
  localparam logic [17:0] IDX_HIGH_COUNT        = 18'h0FE1B;
  localparam logic [17:0] IDX_LOW_MATCH_DATA    = 18'h0FE1C;
  localparam logic [17:0] IDX_HIGH_MATCH_DATA   = 18'h0FE1D;
  localparam logic [17:0] IDX_SOURCE_SELECT     = 18'h0FE1E;

  // ----------------------------------------------------------------
  // timer_control bit positions
  // ----------------------------------------------------------------
  localparam int CTL_HIGH_RUN    = 7;
  localparam int CTL_LOW_RUN     = 6;
  localparam int CTL_CASCADE     = 5;
  localparam int CTL_OUTPUT_MODE = 4;
  localparam int CTL_HIGH_FLAG   = 3;
  localparam int CTL_HIGH_IE     = 2;
  localparam int CTL_LOW_FLAG    = 1;
  localparam int CTL_LOW_IE      = 0;

  // ----------------------------------------------------------------
  // prescaler_control fields: enable plus 3-bit code per byte
  // ----------------------------------------------------------------
  localparam int PRS_HIGH_LSB = 4;
  localparam int PRS_LOW_LSB  = 0;
  localparam int PRS_CFG_W    = 4;
  localparam int PRS_EN_BIT   = 3;

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [7:0]  BYTE_ONE    = 8'h01;
  localparam logic [7:0]  BYTE_FULL   = 8'hFF;
  localparam logic [31:0] RST_WORD    = 32'h00000000;
  localparam logic [8:0]  DIV_BASE    = 9'h001;
endpackage : dbt_pkg

/* File: dbt_timer.sv */
/*
  Dual byte timer: two 8-bit up-counters with prescalers, shadow match
  buffers, toggle/PWM outputs, count-zero flags and an interrupt request.
  Assumes an APB master on the system clock; the event input is
  synchronous to SYS_CLK_I. CLK_EN_I low freezes everything, the bus too.
*/
// Implementation choice: the APB interface to the registers.
// Summary of operation
// - low counter counts prescaler pulses only while low run bit is set
// - high counter counts prescaler pulses only while high run bit is set
// - low counter steps on the low prescaler output
// - high counter steps on the high prescaler output
// - low match when low count equals low match buffer
// - high match when high count equals high match buffer
// - low counter clears when stopped, and on match in modes 0 and 2
// - high counter clears when stopped, and on match except mode 1
// - low buffer follows data while stopped, reloads at zero while running
// - high buffer follows data while stopped, reloads at zero while running
// - low output high when stopped, low when running with data FFH
// - high output high when stopped, low when running with data FFH
// - output mode 0: low output toggles on each low match
// - output mode 1: low output falls on overflow, rises on match
// - high output toggles on match when mode bit 0 or cascade set
// - high output is PWM when mode bit 1 and cascade clear
// - cascade joins bytes: high byte advances at the low byte period
// - both match signals come from their own compares always
// - high flag set when running high count reaches zero; software clears
// - low flag set when running low count reaches zero; software clears
// - interrupt request while either enabled flag is set
// - prescaler writes apply at the next buffer reload while running
// - prescaler divides by 1, or 2 to 256 from its 3-bit code
// - low prescaler fed every 2 clocks or events in modes 0/2, else every clock
`timescale 1ns/10ps
module dbt_timer (
  input  wire logic        SYS_CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        CLK_EN_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [19:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic [3:0]  PSTRB_I,
  input  wire logic        EVENT_INPUT_PIN_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             LOW_WAVE_OUT_O,
  output logic             HIGH_WAVE_OUT_O,
  output logic             IRQ_REQ_O
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // one struct holds all state but the pin flops: comb fills s_d,
  // one register stage copies it, so a low clock
  // enable freezes timer and bus answer alike
  // and no field slips out of step with another
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  prs;
    logic [7:0]  ldata;
    logic [7:0]  hdata;
    logic        srcsel;
    logic [7:0]  lcnt;
    logic [7:0]  hcnt;
    logic [7:0]  lbuf;
    logic [7:0]  hbuf;
    logic [3:0]  lcfg;
    logic [3:0]  hcfg;
    logic [7:0]  lpre;
    logic [7:0]  hpre;
    logic        half;
    logic        ev_prev;
    logic        lwave;
    logic        hwave;
    logic        irq;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
  } dbt_state_type;

  dbt_state_type s_q;
  dbt_state_type s_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // last prescaler count before a pulse: divisor minus one
  // the prescaler counts feeds from zero
  function automatic logic [7:0] dbt_pre_last(input logic [3:0] cfg);
    logic [8:0] div;
    div = dbt_pkg::DIV_BASE;
    if (cfg[dbt_pkg::PRS_EN_BIT]) begin
      // four-bit shift amount: code 7 gives 256
      div = dbt_pkg::DIV_BASE << ({1'b0, cfg[2:0]} + 4'h1);
    end
    dbt_pre_last = 8'(div - dbt_pkg::DIV_BASE);
  endfunction : dbt_pre_last

  // index compare on word addresses
  function automatic logic dbt_hit(input logic [19:0] a, input logic [17:0] idx);
    dbt_hit = (a[19:2] == idx);
  endfunction : dbt_hit

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic       lrun, hrun, cascade, pwm;
  logic       setup, wr;
  logic       lfeed, hfeed, lpulse, hpulse;
  logic       lmatch, hmatch, lmev, hmev, lovf, hovf, lzero, hzero;
  logic [7:0] lnext, hnext;
  logic [7:0] wbyte;
  logic       ev_rise, mapped;

  always_comb begin
    s_d = s_q;
    lrun    = s_q.ctrl[dbt_pkg::CTL_LOW_RUN];
    hrun    = s_q.ctrl[dbt_pkg::CTL_HIGH_RUN];
    cascade = s_q.ctrl[dbt_pkg::CTL_CASCADE];
    pwm     = s_q.ctrl[dbt_pkg::CTL_OUTPUT_MODE];
    ev_rise = EVENT_INPUT_PIN_I & ~s_q.ev_prev;
    wbyte   = PWDATA_I[7:0];

    // bus phases: ready is raised for the access cycle only
    setup = PSEL_I & ~PENABLE_I;
    wr    = PSEL_I & PENABLE_I & s_q.ready & PWRITE_I & PSTRB_I[0];
    mapped = 1'b0;
    if (dbt_hit(PADDR_I, dbt_pkg::IDX_TIMER_CONTROL)) begin
      mapped = 1'b1;
    end else if (dbt_hit(PADDR_I, dbt_pkg::IDX_PRESCALER_CONTROL)) begin
      mapped = 1'b1;
    end else if (dbt_hit(PADDR_I, dbt_pkg::IDX_LOW_COUNT)) begin
      mapped = 1'b1;
    end else if (dbt_hit(PADDR_I, dbt_pkg::IDX_HIGH_COUNT)) begin
      mapped = 1'b1;
    end else if (dbt_hit(PADDR_I, dbt_pkg::IDX_LOW_MATCH_DATA)) begin
      mapped = 1'b1;
    end else if (dbt_hit(PADDR_I, dbt_pkg::IDX_HIGH_MATCH_DATA)) begin
      mapped = 1'b1;
    end else if (dbt_hit(PADDR_I, dbt_pkg::IDX_SOURCE_SELECT)) begin
      mapped = 1'b1;
    end

    // the half-rate tick runs free, so the first
    // step after a start may come a cycle early;
    // later periods are exact. The edge detector
    // idles low like the pin: no false event.
    // 2-cycle tick and event edge
    s_d.half    = ~s_q.half;
    s_d.ev_prev = EVENT_INPUT_PIN_I;

    // low feed: halved clock or events, full clock in PWM modes
    if (pwm) begin
      lfeed = 1'b1;
    end else if (s_q.srcsel) begin
      lfeed = ev_rise;
    end else begin
      lfeed = s_q.half;
    end

    // low prescaler and counter
    lpulse = lrun & lfeed & (s_q.lpre == dbt_pre_last(s_q.lcfg));
    lmatch = (s_q.lcnt == s_q.lbuf);
    lmev   = lpulse & lmatch;
    lovf   = lpulse & (s_q.lcnt == dbt_pkg::BYTE_FULL);
    if (lmev & ~pwm) begin
      lnext = dbt_pkg::BYTE_ZERO;
    end else begin
      lnext = s_q.lcnt + dbt_pkg::BYTE_ONE;
    end
    lzero = lpulse & (lnext == dbt_pkg::BYTE_ZERO);

    // high feed chosen by mode
    if (!cascade) begin
      hfeed = pwm ? 1'b1 : s_q.half;
    end else begin
      hfeed = pwm ? lovf : lmev;
    end
    hpulse = hrun & hfeed & (s_q.hpre == dbt_pre_last(s_q.hcfg));
    hmatch = (s_q.hcnt == s_q.hbuf);
    hmev   = hpulse & hmatch;
    hovf   = hpulse & (s_q.hcnt == dbt_pkg::BYTE_FULL);
    if (hmev & ~(pwm & ~cascade)) begin
      hnext = dbt_pkg::BYTE_ZERO;
    end else begin
      hnext = s_q.hcnt + dbt_pkg::BYTE_ONE;
    end
    hzero = hpulse & (hnext == dbt_pkg::BYTE_ZERO);

    // stopping clears counter and prescaler and
    // parks the wave high, so a restart begins a
    // whole period at zero; buffer and divider
    // track their registers only while stopped
    // low channel update
    if (!lrun) begin
      s_d.lcnt  = dbt_pkg::BYTE_ZERO;
      s_d.lpre  = dbt_pkg::BYTE_ZERO;
      s_d.lbuf  = s_q.ldata;
      s_d.lcfg  = s_q.prs[dbt_pkg::PRS_LOW_LSB +: dbt_pkg::PRS_CFG_W];
      s_d.lwave = 1'b1;
    end else begin
      if (lfeed) begin
        s_d.lpre = lpulse ? dbt_pkg::BYTE_ZERO : s_q.lpre + dbt_pkg::BYTE_ONE;
      end
      if (lpulse) begin
        s_d.lcnt = lnext;
      end
      if (lzero) begin
        s_d.lbuf = s_q.ldata;
        s_d.lcfg = s_q.prs[dbt_pkg::PRS_LOW_LSB +: dbt_pkg::PRS_CFG_W];
      end
      if (pwm) begin
        if (lmev) begin
          s_d.lwave = 1'b1;
        end else if (lovf) begin
          s_d.lwave = 1'b0;
        end
      end else if (lmev) begin
        s_d.lwave = ~s_q.lwave;
      end
    end

    // high channel update
    if (!hrun) begin
      s_d.hcnt  = dbt_pkg::BYTE_ZERO;
      s_d.hpre  = dbt_pkg::BYTE_ZERO;
      s_d.hbuf  = s_q.hdata;
      s_d.hcfg  = s_q.prs[dbt_pkg::PRS_HIGH_LSB +: dbt_pkg::PRS_CFG_W];
      s_d.hwave = 1'b1;
    end else begin
      if (hfeed) begin
        s_d.hpre = hpulse ? dbt_pkg::BYTE_ZERO : s_q.hpre + dbt_pkg::BYTE_ONE;
      end
      if (hpulse) begin
        s_d.hcnt = hnext;
      end
      if (hzero) begin
        s_d.hbuf = s_q.hdata;
        s_d.hcfg = s_q.prs[dbt_pkg::PRS_HIGH_LSB +: dbt_pkg::PRS_CFG_W];
      end
      if (pwm & ~cascade) begin
        if (hmev) begin
          s_d.hwave = 1'b1;
        end else if (hovf) begin
          s_d.hwave = 1'b0;
        end
      end else if (hmev) begin
        s_d.hwave = ~s_q.hwave;
      end
    end

    // count registers are read only: writes to
    // them match no branch and raise no error
    // register writes; flags only clear by writing 0
    if (wr) begin
      if (dbt_hit(PADDR_I, dbt_pkg::IDX_TIMER_CONTROL)) begin
        s_d.ctrl = wbyte;
        s_d.ctrl[dbt_pkg::CTL_HIGH_FLAG] = s_q.ctrl[dbt_pkg::CTL_HIGH_FLAG]
                                         & wbyte[dbt_pkg::CTL_HIGH_FLAG];
        s_d.ctrl[dbt_pkg::CTL_LOW_FLAG]  = s_q.ctrl[dbt_pkg::CTL_LOW_FLAG]
                                         & wbyte[dbt_pkg::CTL_LOW_FLAG];
      end else if (dbt_hit(PADDR_I, dbt_pkg::IDX_PRESCALER_CONTROL)) begin
        s_d.prs = wbyte;
      end else if (dbt_hit(PADDR_I, dbt_pkg::IDX_LOW_MATCH_DATA)) begin
        s_d.ldata = wbyte;
      end else if (dbt_hit(PADDR_I, dbt_pkg::IDX_HIGH_MATCH_DATA)) begin
        s_d.hdata = wbyte;
      end else if (dbt_hit(PADDR_I, dbt_pkg::IDX_SOURCE_SELECT)) begin
        s_d.srcsel = wbyte[0];
      end
    end

    // an event and a clearing write together keep
    // the flag, so no unseen period is lost
    // hardware set wins over a clearing write in the same cycle
    if (hzero) begin
      s_d.ctrl[dbt_pkg::CTL_HIGH_FLAG] = 1'b1;
    end
    if (lzero) begin
      s_d.ctrl[dbt_pkg::CTL_LOW_FLAG] = 1'b1;
    end
    s_d.irq = (s_d.ctrl[dbt_pkg::CTL_HIGH_IE] & s_d.ctrl[dbt_pkg::CTL_HIGH_FLAG])
            | (s_d.ctrl[dbt_pkg::CTL_LOW_IE] & s_d.ctrl[dbt_pkg::CTL_LOW_FLAG]);

    // setup capture keeps PRDATA a flop output;
    // a count read shows the value a cycle early
    // read twice if two values must agree
    // read data is captured in the setup cycle, held through access
    s_d.ready  = setup;
    s_d.slverr = setup & ~mapped;
    if (setup) begin
      s_d.rdata = dbt_pkg::RST_WORD;
      if (dbt_hit(PADDR_I, dbt_pkg::IDX_TIMER_CONTROL)) begin
        s_d.rdata[7:0] = s_q.ctrl;
      end else if (dbt_hit(PADDR_I, dbt_pkg::IDX_PRESCALER_CONTROL)) begin
        s_d.rdata[7:0] = s_q.prs;
      end else if (dbt_hit(PADDR_I, dbt_pkg::IDX_LOW_COUNT)) begin
        s_d.rdata[7:0] = s_q.lcnt;
      end else if (dbt_hit(PADDR_I, dbt_pkg::IDX_HIGH_COUNT)) begin
        s_d.rdata[7:0] = s_q.hcnt;
      end else if (dbt_hit(PADDR_I, dbt_pkg::IDX_LOW_MATCH_DATA)) begin
        s_d.rdata[7:0] = s_q.ldata;
      end else if (dbt_hit(PADDR_I, dbt_pkg::IDX_HIGH_MATCH_DATA)) begin
        s_d.rdata[7:0] = s_q.hdata;
      end else if (dbt_hit(PADDR_I, dbt_pkg::IDX_SOURCE_SELECT)) begin
        s_d.rdata[0] = s_q.srcsel;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // reset zeroes all but the wave levels, which
  // idle high like the pins
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      s_q        <= '0;
      s_q.lwave  <= 1'b1;
      s_q.hwave  <= 1'b1;
      s_q.ctrl   <= dbt_pkg::RST_BYTE;
      s_q.prs    <= dbt_pkg::RST_BYTE;
    end else if (CLK_EN_I) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, registered; pins fixed levels override the waveform
  // ----------------------------------------------------------------
  // fixed levels come from the next state, so a
  // pin moves at the edge its control bit does
  logic low_pin_q, high_pin_q;

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      low_pin_q  <= 1'b1;
      high_pin_q <= 1'b1;
    end else if (CLK_EN_I) begin
      if (!s_d.ctrl[dbt_pkg::CTL_LOW_RUN]) begin
        low_pin_q <= 1'b1;
      end else if (s_d.ldata == dbt_pkg::BYTE_FULL) begin
        low_pin_q <= 1'b0;
      end else begin
        low_pin_q <= s_d.lwave;
      end
      if (!s_d.ctrl[dbt_pkg::CTL_HIGH_RUN]) begin
        high_pin_q <= 1'b1;
      end else if (s_d.hdata == dbt_pkg::BYTE_FULL) begin
        high_pin_q <= 1'b0;
      end else begin
        high_pin_q <= s_d.hwave;
      end
    end
  end

  // every output is a flop: bus answer and
  // request from the struct, pins from their own
  // stage; nothing reaches an output unregistered
  assign PRDATA_O        = s_q.rdata;
  assign PREADY_O        = s_q.ready;
  assign PSLVERR_O       = s_q.slverr;
  assign IRQ_REQ_O       = s_q.irq;
  assign LOW_WAVE_OUT_O  = low_pin_q;
  assign HIGH_WAVE_OUT_O = high_pin_q;
endmodule : dbt_timer

/* File: dbt_event_src.sv */
/*
  Far-side model: drives the external event pin of the timer.
  Assumes the pin is sampled on the system clock, one event per rising edge.
*/
`timescale 1ns/10ps
module dbt_event_src (
  input  wire logic clk_i,
  output logic      event_o
);
  // idle low so an unused source never counts
  initial event_o = 1'b0;

  // one-cycle pulse then a gap, so every edge is clearly separate
  task automatic send(input int n);
    repeat (n) begin
      @(posedge clk_i);
      event_o <= 1'b1;
      @(posedge clk_i);
      event_o <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask : send
endmodule : dbt_event_src

/* File: dbt_timer_monitor.sv */
/*
  Port checker for dbt_timer, bound into every instance.
  Assumes APB writes land at the access edge while ready is high.
*/
`timescale 1ns/10ps
module dbt_timer_monitor (
  input wire logic        SYS_CLK_I,
  input wire logic        SYS_RST_I,
  input wire logic        CLK_EN_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [19:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0]  PSTRB_I,
  input wire logic        EVENT_INPUT_PIN_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        LOW_WAVE_OUT_O,
  input wire logic        HIGH_WAVE_OUT_O,
  input wire logic        IRQ_REQ_O
);
  // ----------------------------------------
  // shadow of what software last wrote
  // ----------------------------------------
  logic [17:0] idx;
  logic        wr;
  logic [7:0]  ctl_q;
  logic [7:0]  ldat_q;
  logic [7:0]  hdat_q;
  assign idx = PADDR_I[19:2];
  assign wr  = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O & PSTRB_I[0] & CLK_EN_I;

  // hardware-set flags are not mirrored, so only run and enable bits are trusted
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      ctl_q  <= 8'h00;
      ldat_q <= 8'h00;
      hdat_q <= 8'h00;
    end else if (wr) begin
      if (idx == dbt_pkg::IDX_TIMER_CONTROL) begin
        ctl_q <= PWDATA_I[7:0];
      end
      if (idx == dbt_pkg::IDX_LOW_MATCH_DATA) begin
        ldat_q <= PWDATA_I[7:0];
      end
      if (idx == dbt_pkg::IDX_HIGH_MATCH_DATA) begin
        hdat_q <= PWDATA_I[7:0];
      end
    end
  end

  default clocking mon_cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  unmapped_error_a: assert property (PREADY_O |->
    PSLVERR_O == (idx < dbt_pkg::IDX_TIMER_CONTROL || idx > dbt_pkg::IDX_SOURCE_SELECT))
    else $error("error response does not match address");
  stopped_count_a: assert property (PREADY_O && !PWRITE_I &&
    (idx == dbt_pkg::IDX_LOW_COUNT && !ctl_q[6] && !$past(ctl_q[6]) && !$past(ctl_q[6], 2) ||
     idx == dbt_pkg::IDX_HIGH_COUNT && !ctl_q[7] && !$past(ctl_q[7]) && !$past(ctl_q[7], 2))
    |-> PRDATA_O[7:0] == 8'h00)
    else $error("stopped counter reads nonzero");
  low_stop_a: assert property (!ctl_q[6] && !$past(ctl_q[6]) |-> LOW_WAVE_OUT_O)
    else $error("low pin not high while stopped");
  high_stop_a: assert property (!ctl_q[7] && !$past(ctl_q[7]) |-> HIGH_WAVE_OUT_O)
    else $error("high pin not high while stopped");
  low_full_a: assert property (ctl_q[6] && $past(ctl_q[6]) && ldat_q == 8'hFF && $past(ldat_q) == 8'hFF
    |-> !LOW_WAVE_OUT_O)
    else $error("low pin not low with full match data");
  high_full_a: assert property (ctl_q[7] && $past(ctl_q[7]) && hdat_q == 8'hFF && $past(hdat_q) == 8'hFF
    |-> !HIGH_WAVE_OUT_O)
    else $error("high pin not low with full match data");
  irq_off_a: assert property (!ctl_q[0] && !ctl_q[2] && !$past(ctl_q[0]) && !$past(ctl_q[2]) |-> !IRQ_REQ_O)
    else $error("request with both enables off");
  irq_hold_a: assert property (IRQ_REQ_O && !wr && !$past(wr) |=> IRQ_REQ_O)
    else $error("request dropped without a write");
endmodule : dbt_timer_monitor

bind dbt_timer dbt_timer_monitor u_mon (
  .SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .CLK_EN_I(CLK_EN_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PSTRB_I(PSTRB_I), .EVENT_INPUT_PIN_I(EVENT_INPUT_PIN_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .LOW_WAVE_OUT_O(LOW_WAVE_OUT_O),
  .HIGH_WAVE_OUT_O(HIGH_WAVE_OUT_O), .IRQ_REQ_O(IRQ_REQ_O));

/* File: tb_top.sv */
/*
  Self-checking bench for the dual byte timer: registers, four modes,
  prescaler codes, flags, request, reload timing and event counting.
  Assumes dbt_pkg, dbt_timer, its monitor and dbt_event_src.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  logic        clk     = 1'b0;
  logic        rst     = 1'b1;
  logic        clk_en  = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [19:0] paddr   = 20'h00000;
  logic [31:0] pwdata  = 32'h00000000;
  logic [3:0]  pstrb   = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        lpin;
  logic        hpin;
  logic        irq;
  logic        evt;
  logic [31:0] rd_v;
  logic        err_v;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cyc        = 0;

  // 10 MHz clock and a free cycle count for timing the pins
  always #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  dbt_timer DUT (
    .SYS_CLK_I        (clk),
    .SYS_RST_I        (rst),
    .CLK_EN_I         (clk_en),
    .PSEL_I           (psel),
    .PENABLE_I        (penable),
    .PWRITE_I         (pwrite),
    .PADDR_I          (paddr),
    .PWDATA_I         (pwdata),
    .PSTRB_I          (pstrb),
    .EVENT_INPUT_PIN_I(evt),
    .PRDATA_O         (prdata),
    .PREADY_O         (pready),
    .PSLVERR_O        (pslverr),
    .LOW_WAVE_OUT_O   (lpin),
    .HIGH_WAVE_OUT_O  (hpin),
    .IRQ_REQ_O        (irq)
  );
  dbt_event_src u_evt (
    .clk_i  (clk),
    .event_o(evt)
  );

  // ----------------------------------------
  // bus and measuring helpers
  // ----------------------------------------
  task automatic apb(input logic w, input logic [17:0] ix, input logic [7:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {ix, 2'b00};
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    // answer taken at the rising edge that samples ready; only the watchdog ends a wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd_v  = prdata;
    err_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic setup(input logic [7:0] c, input logic [7:0] p, input logic [7:0] l, input logic [7:0] h);
    apb(1'b1, dbt_pkg::IDX_TIMER_CONTROL, 8'h00);
    apb(1'b1, dbt_pkg::IDX_PRESCALER_CONTROL, p);
    apb(1'b1, dbt_pkg::IDX_LOW_MATCH_DATA, l);
    apb(1'b1, dbt_pkg::IDX_HIGH_MATCH_DATA, h);
    apb(1'b1, dbt_pkg::IDX_TIMER_CONTROL, c);
  endtask : setup

  task automatic lvl(input bit h, input logic v, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((h ? hpin : lpin) !== v && n < 5000);
  endtask : lvl

  // times one low and one high phase, starting at a fresh falling edge
  task automatic meas(input bit h, input int lo_e, input int hi_e);
    int n;
    int lo;
    int hi;
    lvl(h, 1'b1, n);
    lvl(h, 1'b0, n);
    lvl(h, 1'b1, lo);
    lvl(h, 1'b0, hi);
    `CHK("low time", lo_e, lo)
    `CHK("high time", hi_e, hi)
  endtask : meas

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    for (logic [17:0] ix = dbt_pkg::IDX_TIMER_CONTROL; ix <= dbt_pkg::IDX_SOURCE_SELECT; ix++) begin
      apb(1'b0, ix, 8'h00);
      `CHK("reset value", 32'h00000000, rd_v)
    end
    pstrb <= 4'h0;
    apb(1'b1, dbt_pkg::IDX_PRESCALER_CONTROL, 8'hA5);
    pstrb <= 4'hF;
    apb(1'b0, dbt_pkg::IDX_PRESCALER_CONTROL, 8'h00);
    `CHK("masked write", 32'h00000000, rd_v)
    apb(1'b1, dbt_pkg::IDX_PRESCALER_CONTROL, 8'hA5);
    apb(1'b0, dbt_pkg::IDX_PRESCALER_CONTROL, 8'h00);
    `CHK("prescaler readback", 32'h000000A5, rd_v)
    apb(1'b1, dbt_pkg::IDX_LOW_COUNT, 8'h55);
    apb(1'b0, dbt_pkg::IDX_LOW_COUNT, 8'h00);
    `CHK("count read only", 32'h00000000, rd_v)
    apb(1'b0, dbt_pkg::IDX_SOURCE_SELECT + 18'h1, 8'h00);
    `CHK("unmapped error", 1'b1, err_v)
  endtask : t_regs

  task automatic t_modes();
    setup(8'hC0, 8'h00, 8'h03, 8'h05);
    meas(1'b0, 8, 8);
    meas(1'b1, 12, 12);
    setup(8'hD0, 8'h00, 8'h03, 8'h07);
    meas(1'b0, 4, 252);
    meas(1'b1, 8, 248);
    setup(8'hE0, 8'h00, 8'h01, 8'h01);
    meas(1'b0, 4, 4);
    meas(1'b1, 8, 8);
    setup(8'hF0, 8'h00, 8'h03, 8'h01);
    meas(1'b0, 4, 252);
    meas(1'b1, 512, 512);
  endtask : t_modes

  task automatic t_prescale();
    for (int k = 0; k < 8; k++) begin
      setup(8'hC0, {1'b1, k[2:0], 1'b1, k[2:0]}, 8'h01, 8'h01);
      meas(1'b0, 4 << (k + 1), 4 << (k + 1));
      meas(1'b1, 4 << (k + 1), 4 << (k + 1));
    end
  endtask : t_prescale

  // data and prescaler changed mid-period must wait for the next zero
  task automatic t_reload();
    int n;
    int t0;
    setup(8'h50, 8'h00, 8'd100, 8'h00);
    lvl(1'b0, 1'b1, n);
    lvl(1'b0, 1'b0, n);
    t0 = cyc;
    apb(1'b1, dbt_pkg::IDX_LOW_MATCH_DATA, 8'h03);
    apb(1'b1, dbt_pkg::IDX_PRESCALER_CONTROL, 8'h08);
    lvl(1'b0, 1'b1, n);
    `CHK("old match kept", 101, cyc - t0)
    meas(1'b0, 8, 504);
  endtask : t_reload

  task automatic t_flags();
    setup(8'h41, 8'h00, 8'h03, 8'h00);
    repeat (20) @(negedge clk);
    apb(1'b0, dbt_pkg::IDX_TIMER_CONTROL, 8'h00);
    `CHK("low flag set", 1'b1, rd_v[1])
    `CHK("low request", 1'b1, irq)
    apb(1'b1, dbt_pkg::IDX_TIMER_CONTROL, 8'h03);
    repeat (10) @(negedge clk);
    apb(1'b0, dbt_pkg::IDX_TIMER_CONTROL, 8'h00);
    `CHK("flag kept", 32'h00000003, rd_v)
    apb(1'b1, dbt_pkg::IDX_TIMER_CONTROL, 8'h02);
    repeat (3) @(negedge clk);
    `CHK("masked request", 1'b0, irq)
    apb(1'b1, dbt_pkg::IDX_TIMER_CONTROL, 8'h00);
    apb(1'b0, dbt_pkg::IDX_TIMER_CONTROL, 8'h00);
    `CHK("flag cleared", 32'h00000000, rd_v)
    setup(8'h84, 8'h00, 8'h00, 8'h03);
    repeat (20) @(negedge clk);
    apb(1'b0, dbt_pkg::IDX_TIMER_CONTROL, 8'h00);
    `CHK("high flag set", 1'b1, rd_v[3])
    `CHK("high request", 1'b1, irq)
    apb(1'b1, dbt_pkg::IDX_TIMER_CONTROL, 8'h00);
  endtask : t_flags

  task automatic t_full();
    logic seen;
    repeat (3) @(negedge clk);
    `CHK("stopped pins", 2'b11, {lpin, hpin})
    setup(8'hC0, 8'h00, 8'hFF, 8'hFF);
    seen = 1'b0;
    repeat (2) @(negedge clk);
    repeat (600) begin
      @(negedge clk);
      seen = seen | lpin | hpin;
    end
    `CHK("pins held low", 1'b0, seen)
  endtask : t_full

  // events only with output mode 0, the count source stays valid
  task automatic t_event();
    apb(1'b1, dbt_pkg::IDX_SOURCE_SELECT, 8'h01);
    setup(8'h40, 8'h00, 8'h01, 8'h00);
    repeat (40) @(negedge clk);
    `CHK("no count without events", 1'b1, lpin)
    u_evt.send(2);
    repeat (4) @(negedge clk);
    `CHK("toggle after two events", 1'b0, lpin)
    u_evt.send(2);
    repeat (4) @(negedge clk);
    `CHK("toggle back", 1'b1, lpin)
    apb(1'b1, dbt_pkg::IDX_SOURCE_SELECT, 8'h00);
  endtask : t_event

  // a low clock enable stretches a running phase by the frozen cycles
  task automatic t_freeze();
    int n;
    int t0;
    setup(8'h50, 8'h00, 8'd100, 8'h00);
    lvl(1'b0, 1'b1, n);
    lvl(1'b0, 1'b0, n);
    t0 = cyc;
    @(posedge clk);
    clk_en <= 1'b0;
    repeat (20) @(posedge clk);
    clk_en <= 1'b1;
    lvl(1'b0, 1'b1, n);
    `CHK("frozen phase", 121, cyc - t0)
  endtask : t_freeze

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // main sequence, reset held for six cycles
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_modes();
    t_prescale();
    t_reload();
    t_flags();
    t_full();
    t_event();
    t_freeze();
    complete_run();
  end

  // watchdog: the run needs about 20k cycles, this allows 60k
  initial begin
    #6000000;
    num_errors++;
    complete_run();
  end
endmodule : tb_top
